// *** design/sev_event_vector_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module sev_event_vector_unit #(
  parameter int unsigned MBOX_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Peripheral read port
  input wire logic per_rd,
  input wire logic [15:0] per_addr,
  output logic [sev_pkg::DATA_W-1:0] per_rdata,
  output logic per_ack,
  // Brownout-class event pulses
  input wire logic brownout_evt,
  input wire logic reset_pin_flag,
  input wire logic software_brownout_request,
  input wire logic lpm_wake_evt,
  input wire logic security_evt,
  input wire logic supply_supervisor_flag,
  // Power-on-class event pulse
  input wire logic software_poweron_request,
  // Power-up-clear event pulses and the reset enables that route them
  input wire logic watchdog_expiry_flag,
  input wire logic watchdog_password,
  input wire logic nvm_controller_password,
  input wire logic nvm_uncorrectable_evt,
  input wire logic nvm_uncorrectable_reset_en,
  input wire logic periph_fetch_evt,
  input wire logic power_mgmt_password,
  input wire logic protection_unit_password,
  input wire logic clock_system_password,
  input wire logic encapsulated_region_violation_flag,
  input wire logic info_memory_violation_flag,
  input wire logic segment_one_violation_flag,
  input wire logic segment_two_violation_flag,
  input wire logic segment_three_violation_flag,
  input wire logic violation_reset_en,
  input wire logic access_time_error_flag,
  // System-NMI-only event pulses
  input wire logic vacant_access_flag,
  input wire logic nvm_corrected_evt,
  // User-NMI event pulses
  input wire logic nmi_pin_flag,
  input wire logic oscillator_fault_flag,
  // Debugger side of the mailbox
  input wire logic dbg_wr,
  input wire logic [MBOX_W-1:0] dbg_wdata,
  input wire logic dbg_rd,
  output logic [MBOX_W-1:0] dbg_rdata,
  // Software side of the mailbox
  input wire logic sw_mbox_wr,
  input wire logic [MBOX_W-1:0] sw_mbox_wdata,
  input wire logic sw_mbox_rd,
  output logic [MBOX_W-1:0] sw_mbox_rdata,
  output logic mailbox_in_flag,
  output logic mailbox_out_flag,
  // Reset requests toward the reset tree
  output logic brownout_class_reset,
  output logic poweron_class_reset,
  output logic power_up_clear_reset,
  // Pending summaries
  output logic snmi_pending,
  output logic unmi_pending
);

  localparam int unsigned RN = sev_pkg::RESET_SLOTS;
  localparam int unsigned SN = sev_pkg::SNMI_SLOTS;
  localparam int unsigned UN = sev_pkg::UNMI_SLOTS;

  // Read strobe aimed at one vector address
  function automatic logic hit(input logic rd, input logic [15:0] a,
                               input logic [15:0] reg_addr);
    hit = rd & (a == reg_addr);
  endfunction : hit

  // ==========================================================
  // Reset synchroniser
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // Mailbox
  logic mbox_in_evt;
  logic mbox_out_evt;

  sev_mailbox #(
    .W(MBOX_W)
  ) u_mailbox (
    .clk(clk),
    .rst_n(rst_n),
    .dbg_wr(dbg_wr),
    .dbg_wdata(dbg_wdata),
    .dbg_rd(dbg_rd),
    .dbg_rdata(dbg_rdata),
    .sw_wr(sw_mbox_wr),
    .sw_wdata(sw_mbox_wdata),
    .sw_rd(sw_mbox_rd),
    .sw_rdata(sw_mbox_rdata),
    .mailbox_in_flag(mailbox_in_flag),
    .mailbox_out_flag(mailbox_out_flag),
    .in_event(mbox_in_evt),
    .out_event(mbox_out_evt)
  );

  // ==========================================================
  // Event to slot mapping; reserved slots never set
  logic [RN-1:0] rst_set;
  logic [SN-1:0] snmi_set;
  logic [UN-1:0] unmi_set;
  logic nvm_uncorr_rst;
  logic viol_rst;

  // Protection faults and uncorrectable errors reset only when enabled;
  // otherwise they stay system NMIs.
  assign nvm_uncorr_rst = nvm_uncorrectable_evt & nvm_uncorrectable_reset_en;
  assign viol_rst = violation_reset_en;

  always_comb
  begin
    rst_set = '0;
    rst_set[sev_pkg::slot(sev_pkg::RC_BROWNOUT)] = brownout_evt;
    rst_set[sev_pkg::slot(sev_pkg::RC_RESET_PIN)] = reset_pin_flag;
    rst_set[sev_pkg::slot(sev_pkg::RC_SW_BROWNOUT)] =
      software_brownout_request;
    rst_set[sev_pkg::slot(sev_pkg::RC_LPM_WAKE)] = lpm_wake_evt;
    rst_set[sev_pkg::slot(sev_pkg::RC_SECURITY)] = security_evt;
    rst_set[sev_pkg::slot(sev_pkg::RC_SUPPLY_SUP)] =
      supply_supervisor_flag;
    rst_set[sev_pkg::slot(sev_pkg::RC_SW_POWERON)] =
      software_poweron_request;
    rst_set[sev_pkg::slot(sev_pkg::RC_WATCHDOG)] =
      watchdog_expiry_flag;
    rst_set[sev_pkg::slot(sev_pkg::RC_WDOG_PASSWORD)] =
      watchdog_password;
    rst_set[sev_pkg::slot(sev_pkg::RC_NVM_PASSWORD)] =
      nvm_controller_password;
    rst_set[sev_pkg::slot(sev_pkg::RC_NVM_UNCORR)] = nvm_uncorr_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_PERIPH_FETCH)] =
      periph_fetch_evt;
    rst_set[sev_pkg::slot(sev_pkg::RC_PMM_PASSWORD)] =
      power_mgmt_password;
    rst_set[sev_pkg::slot(sev_pkg::RC_MPU_PASSWORD)] =
      protection_unit_password;
    rst_set[sev_pkg::slot(sev_pkg::RC_CLK_PASSWORD)] =
      clock_system_password;
    rst_set[sev_pkg::slot(sev_pkg::RC_ENCAP_VIOL)] =
      encapsulated_region_violation_flag & viol_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_INFO_VIOL)] =
      info_memory_violation_flag & viol_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_SEG1_VIOL)] =
      segment_one_violation_flag & viol_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_SEG2_VIOL)] =
      segment_two_violation_flag & viol_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_SEG3_VIOL)] =
      segment_three_violation_flag & viol_rst;
    rst_set[sev_pkg::slot(sev_pkg::RC_ACCESS_TIME)] =
      access_time_error_flag;
  end

  always_comb
  begin
    snmi_set = '0;
    snmi_set[sev_pkg::slot(sev_pkg::SN_NVM_UNCORR)] =
      nvm_uncorrectable_evt & ~nvm_uncorrectable_reset_en;
    snmi_set[sev_pkg::slot(sev_pkg::SN_ENCAP_VIOL)] =
      encapsulated_region_violation_flag & ~viol_rst;
    snmi_set[sev_pkg::slot(sev_pkg::SN_INFO_VIOL)] =
      info_memory_violation_flag & ~viol_rst;
    snmi_set[sev_pkg::slot(sev_pkg::SN_SEG1_VIOL)] =
      segment_one_violation_flag & ~viol_rst;
    snmi_set[sev_pkg::slot(sev_pkg::SN_SEG2_VIOL)] =
      segment_two_violation_flag & ~viol_rst;
    snmi_set[sev_pkg::slot(sev_pkg::SN_SEG3_VIOL)] =
      segment_three_violation_flag & ~viol_rst;
    snmi_set[sev_pkg::slot(sev_pkg::SN_VACANT)] = vacant_access_flag;
    snmi_set[sev_pkg::slot(sev_pkg::SN_MBOX_IN)] = mbox_in_evt;
    snmi_set[sev_pkg::slot(sev_pkg::SN_MBOX_OUT)] = mbox_out_evt;
    snmi_set[sev_pkg::slot(sev_pkg::SN_NVM_CORR)] = nvm_corrected_evt;
  end

  always_comb
  begin
    unmi_set = '0;
    unmi_set[sev_pkg::slot(sev_pkg::UN_NMI_PIN)] = nmi_pin_flag;
    unmi_set[sev_pkg::slot(sev_pkg::UN_OSC_FAULT)] =
      oscillator_fault_flag;
  end

  // ==========================================================
  // Sticky flags and priority pick
  logic [RN-1:0] rst_flag_r;
  logic [SN-1:0] snmi_flag_r;
  logic [UN-1:0] unmi_flag_r;
  logic [RN-1:0] rst_pick;
  logic [SN-1:0] snmi_pick;
  logic [UN-1:0] unmi_pick;
  logic [sev_pkg::DATA_W-1:0] rst_code;
  logic [sev_pkg::DATA_W-1:0] snmi_code;
  logic [sev_pkg::DATA_W-1:0] unmi_code;
  logic rd_rst;
  logic rd_snmi;
  logic rd_unmi;

  sev_vec_pick #(.N(RN)) u_pick_rst (
    .flags(rst_flag_r),
    .code(rst_code),
    .pick(rst_pick)
  );
  sev_vec_pick #(.N(SN)) u_pick_snmi (
    .flags(snmi_flag_r),
    .code(snmi_code),
    .pick(snmi_pick)
  );
  sev_vec_pick #(.N(UN)) u_pick_unmi (
    .flags(unmi_flag_r),
    .code(unmi_code),
    .pick(unmi_pick)
  );
  assign rd_rst = hit(per_rd, per_addr, sev_pkg::RESET_CAUSE_VECTOR_ADDR);
  assign rd_snmi = hit(per_rd, per_addr, sev_pkg::SYSTEM_NMI_VECTOR_ADDR);
  assign rd_unmi = hit(per_rd, per_addr, sev_pkg::USER_NMI_VECTOR_ADDR);

  // A new event on the slot being read survives: set beats clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_flag_r <= '0;
    else
      rst_flag_r <= (rst_flag_r & ~(rst_pick & {RN{rd_rst}})) |
                    rst_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      snmi_flag_r <= '0;
    else
      snmi_flag_r <= (snmi_flag_r & ~(snmi_pick & {SN{rd_snmi}})) |
                     snmi_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unmi_flag_r <= '0;
    else
      unmi_flag_r <= (unmi_flag_r & ~(unmi_pick & {UN{rd_unmi}})) |
                     unmi_set;
  end

  // ==========================================================
  // Read data; unmapped addresses answer zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_rdata <= sev_pkg::NO_PENDING;
      per_ack <= 1'b0;
    end
    else
    begin
      per_ack <= per_rd;
      if (rd_rst)
        per_rdata <= rst_code;
      else if (rd_snmi)
        per_rdata <= snmi_code;
      else if (rd_unmi)
        per_rdata <= unmi_code;
      else
        per_rdata <= sev_pkg::NO_PENDING;
    end
  end

  // ==========================================================
  // Reset class requests, one cycle per event cycle
  logic bor_any;
  logic pwr_any;
  logic puc_any;

  assign bor_any = |rst_set[sev_pkg::slot(sev_pkg::RC_SUPPLY_SUP):0];
  assign pwr_any = rst_set[sev_pkg::slot(sev_pkg::RC_SW_POWERON)];
  assign puc_any = |rst_set[RN-1:sev_pkg::slot(sev_pkg::RC_WATCHDOG)];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brownout_class_reset <= 1'b0;
      poweron_class_reset <= 1'b0;
      power_up_clear_reset <= 1'b0;
      snmi_pending <= 1'b0;
      unmi_pending <= 1'b0;
    end
    else
    begin
      brownout_class_reset <= bor_any;
      poweron_class_reset <= pwr_any;
      power_up_clear_reset <= puc_any;
      snmi_pending <= |snmi_flag_r;
      unmi_pending <= |unmi_flag_r;
    end
  end

endmodule : sev_event_vector_unit

`default_nettype wire

// *** design/sev_pkg.sv ***
`default_nettype none

package sev_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] USER_NMI_VECTOR_ADDR = 16'h019A;
  localparam logic [15:0] SYSTEM_NMI_VECTOR_ADDR = 16'h019C;
  localparam logic [15:0] RESET_CAUSE_VECTOR_ADDR = 16'h019E;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] NO_PENDING = 16'h0000;

  // ==========================================================
  // Flag slots per class: slot i reports code 2*(i+1)
  localparam int unsigned RESET_SLOTS = 24;
  localparam int unsigned SNMI_SLOTS = 12;
  localparam int unsigned UNMI_SLOTS = 2;

  // ==========================================================
  // Reset-cause codes
  localparam logic [7:0] RC_BROWNOUT = 8'h02;
  localparam logic [7:0] RC_RESET_PIN = 8'h04;
  localparam logic [7:0] RC_SW_BROWNOUT = 8'h06;
  localparam logic [7:0] RC_LPM_WAKE = 8'h08;
  localparam logic [7:0] RC_SECURITY = 8'h0A;
  localparam logic [7:0] RC_SUPPLY_SUP = 8'h0E;
  localparam logic [7:0] RC_SW_POWERON = 8'h14;
  localparam logic [7:0] RC_WATCHDOG = 8'h16;
  localparam logic [7:0] RC_WDOG_PASSWORD = 8'h18;
  localparam logic [7:0] RC_NVM_PASSWORD = 8'h1A;
  localparam logic [7:0] RC_NVM_UNCORR = 8'h1C;
  localparam logic [7:0] RC_PERIPH_FETCH = 8'h1E;
  localparam logic [7:0] RC_PMM_PASSWORD = 8'h20;
  localparam logic [7:0] RC_MPU_PASSWORD = 8'h22;
  localparam logic [7:0] RC_CLK_PASSWORD = 8'h24;
  localparam logic [7:0] RC_ENCAP_VIOL = 8'h26;
  localparam logic [7:0] RC_INFO_VIOL = 8'h28;
  localparam logic [7:0] RC_SEG1_VIOL = 8'h2A;
  localparam logic [7:0] RC_SEG2_VIOL = 8'h2C;
  localparam logic [7:0] RC_SEG3_VIOL = 8'h2E;
  localparam logic [7:0] RC_ACCESS_TIME = 8'h30;

  // ==========================================================
  // System-NMI codes
  localparam logic [7:0] SN_NVM_UNCORR = 8'h04;
  localparam logic [7:0] SN_ENCAP_VIOL = 8'h08;
  localparam logic [7:0] SN_INFO_VIOL = 8'h0A;
  localparam logic [7:0] SN_SEG1_VIOL = 8'h0C;
  localparam logic [7:0] SN_SEG2_VIOL = 8'h0E;
  localparam logic [7:0] SN_SEG3_VIOL = 8'h10;
  localparam logic [7:0] SN_VACANT = 8'h12;
  localparam logic [7:0] SN_MBOX_IN = 8'h14;
  localparam logic [7:0] SN_MBOX_OUT = 8'h16;
  localparam logic [7:0] SN_NVM_CORR = 8'h18;

  // ==========================================================
  // User-NMI codes
  localparam logic [7:0] UN_NMI_PIN = 8'h02;
  localparam logic [7:0] UN_OSC_FAULT = 8'h04;

  // Slot index of a code
  function automatic int unsigned slot(input logic [7:0] code);
    slot = 32'(code[7:1]) - 32'h1;
  endfunction : slot

endpackage : sev_pkg

`default_nettype wire

// *** design/sev_vec_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

module sev_vec_pick #(
  parameter int unsigned N = 2
) (
  // Pending flags, slot 0 highest priority
  input wire logic [N-1:0] flags,
  // Winning code and its one-hot slot
  output logic [sev_pkg::DATA_W-1:0] code,
  output logic [N-1:0] pick
);

  // ==========================================================
  // Lowest slot wins; scan downward so the last hit is the lowest
  always_comb
  begin
    code = sev_pkg::NO_PENDING;
    pick = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (flags[i])
      begin
        code = sev_pkg::DATA_W'((i + 1) * 2);
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

endmodule : sev_vec_pick

`default_nettype wire

// *** design/sev_mailbox.sv ***
`timescale 1ns/1ps
`default_nettype none

module sev_mailbox #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Debugger side
  input wire logic dbg_wr,
  input wire logic [W-1:0] dbg_wdata,
  input wire logic dbg_rd,
  output logic [W-1:0] dbg_rdata,
  // Software side
  input wire logic sw_wr,
  input wire logic [W-1:0] sw_wdata,
  input wire logic sw_rd,
  output logic [W-1:0] sw_rdata,
  // Flags and events
  output logic mailbox_in_flag,
  output logic mailbox_out_flag,
  output logic in_event,
  output logic out_event
);

  // ==========================================================
  // Incoming word: debugger fills, software drains
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_rdata <= '0;
      mailbox_in_flag <= 1'b0;
      in_event <= 1'b0;
    end
    else
    begin
      if (dbg_wr)
        sw_rdata <= dbg_wdata;
      // A fresh word beats a read in the same cycle
      mailbox_in_flag <= dbg_wr | (mailbox_in_flag & ~sw_rd);
      in_event <= dbg_wr;
    end
  end

  // ==========================================================
  // Outgoing word: software fills, debugger takes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_rdata <= '0;
      mailbox_out_flag <= 1'b0;
      out_event <= 1'b0;
    end
    else
    begin
      if (sw_wr)
        dbg_rdata <= sw_wdata;
      mailbox_out_flag <= sw_wr | (mailbox_out_flag & ~dbg_rd);
      out_event <= dbg_rd & mailbox_out_flag;
    end
  end

endmodule : sev_mailbox

`default_nettype wire

// *** tb/sev_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sev_cpu_model (
  // Clock
  input wire logic clk,
  // Peripheral read port
  output logic per_rd,
  output logic [15:0] per_addr,
  input wire logic [15:0] per_rdata,
  input wire logic per_ack
);
  initial
  begin
    per_rd = 1'b0;
    per_addr = 16'h0000;
  end

  // ==========================================================
  // One read; the strobe is a single-cycle pulse because each vector read
  // clears the flag it reports, while the address stands until the answer
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int n;
    d = 16'hDEAD;
    n = 0;
    @(posedge clk);
    per_rd <= 1'b1;
    per_addr <= a;
    @(posedge clk);
    per_rd <= 1'b0;
    #1;
    while (per_ack !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (per_ack === 1'b1)
      d = per_rdata;
  endtask : rd
endmodule : sev_cpu_model

`default_nettype wire

// *** tb/sev_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module sev_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Read port
  input wire logic per_rd,
  input wire logic [15:0] per_addr,
  input wire logic [sev_pkg::DATA_W-1:0] per_rdata,
  input wire logic per_ack,
  // Events and routing
  input wire logic brownout_evt,
  input wire logic reset_pin_flag,
  input wire logic software_brownout_request,
  input wire logic software_poweron_request,
  input wire logic watchdog_expiry_flag,
  input wire logic watchdog_password,
  input wire logic nvm_uncorrectable_evt,
  input wire logic nvm_uncorrectable_reset_en,
  input wire logic segment_two_violation_flag,
  input wire logic violation_reset_en,
  input wire logic vacant_access_flag,
  input wire logic nmi_pin_flag,
  // Mailbox
  input wire logic dbg_wr,
  input wire logic [15:0] dbg_wdata,
  input wire logic [15:0] sw_mbox_rdata,
  input wire logic mailbox_in_flag,
  // Outputs
  input wire logic brownout_class_reset,
  input wire logic poweron_class_reset,
  input wire logic power_up_clear_reset,
  input wire logic snmi_pending,
  input wire logic unmi_pending
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Read port
  a_read_ack_next: assert property (per_rd |=> per_ack)
    else $error("read not acknowledged");
  a_ack_has_read: assert property (per_ack |-> $past(per_rd))
    else $error("ack without read");
  a_unmapped_zero: assert property (per_rd && !(per_addr inside
    {16'h019A, 16'h019C, 16'h019E}) |=> per_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // ==========================================================
  // Reset class requests
  a_brownout_pulse: assert property ((brownout_evt || reset_pin_flag ||
    software_brownout_request) |=> brownout_class_reset)
    else $error("brownout request missing");
  a_poweron_only: assert property (poweron_class_reset |->
    $past(software_poweron_request))
    else $error("stray power-on request");
  a_watchdog_puc: assert property ((watchdog_expiry_flag ||
    watchdog_password) |=> power_up_clear_reset)
    else $error("watchdog clear missing");
  a_route_uncorr: assert property (nvm_uncorrectable_evt |=>
    power_up_clear_reset == $past(nvm_uncorrectable_reset_en))
    else $error("uncorrectable routing wrong");
  a_seg_route: assert property (segment_two_violation_flag &&
    violation_reset_en |=> power_up_clear_reset)
    else $error("segment clear missing");

  // ==========================================================
  // NMI summaries and mailbox
  a_user_pending: assert property (nmi_pin_flag |-> ##2 unmi_pending)
    else $error("user nmi not pending");
  a_vacant_pending: assert property (vacant_access_flag |->
    ##2 snmi_pending)
    else $error("system nmi not pending");
  a_mbox_word: assert property (dbg_wr |=> mailbox_in_flag &&
    sw_mbox_rdata == $past(dbg_wdata))
    else $error("mailbox word lost");

  c_read_code: cover property (per_ack && per_rdata != 16'h0000);
  c_brownout: cover property (brownout_class_reset);
  c_mbox: cover property (mailbox_in_flag && snmi_pending);
endmodule : sev_assertions

bind sev_event_vector_unit sev_assertions sev_assertions_inst (
  .clk, .rstn, .per_rd, .per_addr, .per_rdata, .per_ack, .brownout_evt,
  .reset_pin_flag, .software_brownout_request, .software_poweron_request,
  .watchdog_expiry_flag, .watchdog_password, .nvm_uncorrectable_evt,
  .nvm_uncorrectable_reset_en, .segment_two_violation_flag,
  .violation_reset_en, .vacant_access_flag, .nmi_pin_flag, .dbg_wr,
  .dbg_wdata, .sw_mbox_rdata, .mailbox_in_flag, .brownout_class_reset,
  .poweron_class_reset, .power_up_clear_reset, .snmi_pending, .unmi_pending
);

`default_nettype wire

// *** tb/test_sev_event_vector_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_sev_event_vector_unit;
  localparam logic [15:0] UNV = sev_pkg::USER_NMI_VECTOR_ADDR;
  localparam logic [15:0] SNV = sev_pkg::SYSTEM_NMI_VECTOR_ADDR;
  localparam logic [15:0] RCV = sev_pkg::RESET_CAUSE_VECTOR_ADDR;
  // Expected codes: RCT has the code for ev[i] in byte i, SNT the system-NMI codes in read order
  localparam logic [167:0] RCT = {8'h30, 8'h2E, 8'h2C, 8'h2A, 8'h28,
    8'h26, 8'h24, 8'h22, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h16, 8'h14,
    8'h0E, 8'h0A, 8'h08, 8'h06, 8'h04, 8'h02};
  localparam logic [79:0] SNT = {8'h18, 8'h16, 8'h14, 8'h12, 8'h10, 8'h0E,
    8'h0C, 8'h0A, 8'h08, 8'h04};

  logic clk;
  logic rstn = 1'b0;
  logic per_rd, per_ack;
  logic [15:0] per_addr, per_rdata, dbg_rdata, sw_mbox_rdata;
  logic [24:0] ev = '0;
  logic unc_en = 1'b1;
  logic viol_en = 1'b1;
  logic dbg_wr = 1'b0;
  logic dbg_rd = 1'b0;
  logic sw_mbox_wr = 1'b0;
  logic sw_mbox_rd = 1'b0;
  logic [15:0] dbg_wdata = 16'h0000;
  logic [15:0] sw_mbox_wdata = 16'h0000;
  logic mailbox_in_flag, mailbox_out_flag, snmi_pending, unmi_pending;
  logic brownout_class_reset, poweron_class_reset, power_up_clear_reset;
  int bad_count = 0;
  int checked = 0;

  sev_event_vector_unit sev_event_vector_unit_inst (
    .clk, .rstn, .per_rd, .per_addr, .per_rdata, .per_ack,
    .brownout_evt(ev[0]), .reset_pin_flag(ev[1]),
    .software_brownout_request(ev[2]), .lpm_wake_evt(ev[3]),
    .security_evt(ev[4]), .supply_supervisor_flag(ev[5]),
    .software_poweron_request(ev[6]), .watchdog_expiry_flag(ev[7]),
    .watchdog_password(ev[8]), .nvm_controller_password(ev[9]),
    .nvm_uncorrectable_evt(ev[10]), .nvm_uncorrectable_reset_en(unc_en),
    .periph_fetch_evt(ev[11]), .power_mgmt_password(ev[12]),
    .protection_unit_password(ev[13]), .clock_system_password(ev[14]),
    .encapsulated_region_violation_flag(ev[15]),
    .info_memory_violation_flag(ev[16]), .segment_one_violation_flag(ev[17]),
    .segment_two_violation_flag(ev[18]),
    .segment_three_violation_flag(ev[19]), .violation_reset_en(viol_en),
    .access_time_error_flag(ev[20]), .vacant_access_flag(ev[21]),
    .nvm_corrected_evt(ev[22]), .nmi_pin_flag(ev[23]),
    .oscillator_fault_flag(ev[24]), .dbg_wr, .dbg_wdata, .dbg_rd, .dbg_rdata,
    .sw_mbox_wr, .sw_mbox_wdata, .sw_mbox_rd, .sw_mbox_rdata,
    .mailbox_in_flag, .mailbox_out_flag, .brownout_class_reset,
    .poweron_class_reset, .power_up_clear_reset, .snmi_pending, .unmi_pending
  );

  sev_cpu_model sev_cpu_model_inst (
    .clk, .per_rd, .per_addr, .per_rdata, .per_ack
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic conclude();
    $display("compared %0d mismatched %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    sev_cpu_model_inst.rd(a, d);
    chk(d, exp);
  endtask : rdc

  // Events are one-cycle pulses; class requests are visible on return
  task automatic fire(input logic [24:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask : fire

  // Op bits: debugger write, software write, debugger take, software take
  task automatic mbx(input logic [3:0] op, input logic [15:0] w);
    @(posedge clk);
    {dbg_wr, sw_mbox_wr, dbg_rd, sw_mbox_rd} <= op;
    dbg_wdata <= w;
    sw_mbox_wdata <= w;
    @(posedge clk);
    {dbg_wr, sw_mbox_wr, dbg_rd, sw_mbox_rd} <= 4'h0;
    #1;
  endtask : mbx

  // ==========================================================
  // Tests
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(RCV, 16'h0000);
    for (int i = 0; i < 21; i++)
    begin
      fire(25'h0000001 << i);
      chk({13'h0000, brownout_class_reset, poweron_class_reset,
        power_up_clear_reset}, {13'h0000, i < 6, i == 6, i > 6});
      rdc(RCV, {8'h00, RCT[i*8 +: 8]});
      rdc(RCV, 16'h0000);
    end
    // All reset causes at once: reads walk them in priority order
    fire(25'h01FFFFF);
    for (int i = 0; i < 21; i++)
      rdc(RCV, {8'h00, RCT[i*8 +: 8]});
    rdc(RCV, 16'h0000);
    @(posedge clk);
    unc_en <= 1'b0;
    viol_en <= 1'b0;
    mbx(4'h8, 16'hA5C3);
    chk({mailbox_in_flag, 15'h0000}, 16'h8000);
    chk(sw_mbox_rdata, 16'hA5C3);
    mbx(4'h4, 16'h3C5A);
    chk({mailbox_out_flag, 15'h0000}, 16'h8000);
    chk(dbg_rdata, 16'h3C5A);
    mbx(4'h2, 16'h0000);
    mbx(4'h1, 16'h0000);
    chk({14'h0000, mailbox_in_flag, mailbox_out_flag}, 16'h0000);
    fire(25'h06F8400);
    chk({15'h0000, power_up_clear_reset}, 16'h0000);
    chk({15'h0000, snmi_pending}, 16'h0001);
    for (int i = 0; i < 10; i++)
      rdc(SNV, {8'h00, SNT[i*8 +: 8]});
    rdc(SNV, 16'h0000);
    chk({15'h0000, snmi_pending}, 16'h0000);
    fire(25'h1800000);
    rdc(UNV, 16'h0002);
    chk({15'h0000, unmi_pending}, 16'h0001);
    rdc(UNV, 16'h0004);
    rdc(UNV, 16'h0000);
    chk({15'h0000, unmi_pending}, 16'h0000);
    // A mid-run reset must drop pending causes of every class
    fire(25'h0A00001);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(RCV, 16'h0000);
    rdc(SNV, 16'h0000);
    rdc(UNV, 16'h0000);
    rdc(16'h01A0, 16'h0000);
    conclude();
  end

  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule : test_sev_event_vector_unit

`default_nettype wire
